// File: tsp_timer.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "tsp_map.svh"

// How it works
// RL1 - software selects single pulse with mode 10 and pin function 11, unchanged
// RL2 - run bit rising starts counter and drives pulse leading edge
// RL3 - external trigger edge in pulse mode sets the run bit
// RL4 - clearing run bit ends the pulse; run stays high while active
// RL5 - compare A match in pulse mode clears run bit, ending the pulse
// RL6 - compare A match in pulse mode raises the interrupt request
// RL7 - in pulse mode counter clears only on run bit rising
// RL8 - pulse mode ignores period value, clear select and swap bit
// RL9 - software selects capture with mode field 01
// RL10 - capture mode counter starts on run bit rising
// RL11 - selected capture edge copies counter into compare A, raises interrupt
// RL12 - pin function picks rising, falling, both; 11 disables capture only
// RL13 - capture mode counter runs regardless of pin until run falls
// RL14 - capture mode period match resets counter to zero
// RL15 - capture mode period match raises interrupt request
// RL16 - period zero lets counter run to full count before wrapping
// RL17 - capture mode has no output; level, invert, clear, swap ignored
// RL18 - capture pin watched even when configured as output
// RL19 - counter is ten bits wide
// RL20 - period value compared with counter bits nine to seven
// RL21 - run falling stops counter, value held until run rises
// RL22 - run bit and trigger sampled on clock, edges by previous level
// RL23 - capture pin chosen by outside pin-sharing select input
module tsp_timer
	import tsp_pkg::*;
(
	input  wire logic       core_clk,            // system clock
	input  wire logic       reset_n,             // async reset, active low
	input  wire logic       count_tick,          // timer clock enable pulse
	input  tsp_bus_req_type bus_req,             // software register port
	output logic      [9:0] bus_rdata,           // read data, cycle after read
	input  wire logic       external_trigger_pin,// pulse trigger input
	input  wire logic       capture_pin_first,   // capture input, first pin
	input  wire logic       capture_pin_second,  // capture input, second pin
	input  wire logic       capture_pin_select,  // pin-sharing: 1 picks second
	output logic            timer_out,           // pulse output pin
	output logic            timer_irq            // interrupt request pulse
);

	tsp_ctrl_type ctrl_reg;
	tsp_ctrl_type ctrl_next;
	logic [2:0]   period_value_p;
	logic [9:0]   compare_value_a;
	logic [9:0]   count_reg;
	logic [9:0]   count_next;
	logic         run_prev_reg;
	logic         trig_prev_reg;
	logic         cap_prev_reg;
	logic         pulse_reg;

	wire logic [1:0] mode_w     = {ctrl_reg.timer_mode_sel_hi, ctrl_reg.timer_mode_sel_lo};
	wire logic [1:0] pinf_w     = {ctrl_reg.pin_function_sel_hi, ctrl_reg.pin_function_sel_lo};
	wire logic       pulse_mode = (mode_w == `TSP_MODE_PULSE) && (pinf_w == `TSP_PIN_PULSE);
	wire logic       cap_mode   = (mode_w == `TSP_MODE_CAPTURE);
	wire logic       run        = ctrl_reg.counter_run_bit;
	wire logic       run_rise   = run && !run_prev_reg;                          // RL22
	wire logic       trig_rise  = external_trigger_pin && !trig_prev_reg;         // RL22
	wire logic       cap_pin    = capture_pin_select ? capture_pin_second : capture_pin_first; // RL23 RL18
	wire logic       cap_rise   = cap_pin && !cap_prev_reg;
	wire logic       cap_fall   = !cap_pin && cap_prev_reg;
	wire logic       cap_edge   = (pinf_w == `TSP_PIN_RISE) ? cap_rise :
	                              (pinf_w == `TSP_PIN_FALL) ? cap_fall :
	                              (pinf_w == `TSP_PIN_BOTH) ? (cap_rise || cap_fall) : 1'b0; // RL12
	wire logic       do_capture = cap_mode && run && cap_edge;                   // RL11
	wire logic       counting   = run && !run_rise && count_tick;                 // RL21
	wire logic       match_a    = pulse_mode && counting && (count_reg == compare_value_a); // RL5
	wire logic       p_hit      = (period_value_p == `TSP_PERIOD_FULL) ? (count_reg == `TSP_COUNT_MAX) :
	                              (count_reg[9:7] == period_value_p);                 // RL16 RL20
	wire logic       match_p    = cap_mode && counting && p_hit;                      // RL14
	wire logic       active_lvl = ctrl_reg.output_initial_level ^ ctrl_reg.output_invert;
	wire logic       ctrl_wr    = bus_req.wr && (bus_req.addr == `TSP_ADDR_CTRL);
	wire logic       trig_set   = pulse_mode && trig_rise;                       // RL3

	always_comb begin
		ctrl_next = ctrl_reg;
		if (ctrl_wr)
			ctrl_next = tsp_ctrl_type'(bus_req.wdata[8:0]);
		if (match_a)
			ctrl_next.counter_run_bit = 1'b0;                                // RL5
		if (trig_set)
			ctrl_next.counter_run_bit = 1'b1;                                // RL3
	end

	always_comb begin
		count_next = count_reg;
		if (run_rise)
			count_next = `TSP_RST_COUNT;                                      // RL7 RL10
		else if (match_p)
			count_next = `TSP_RST_COUNT;                                      // RL14
		else if (counting && !match_a)
			count_next = count_reg + 10'h001;                                 // RL13 RL19
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg       <= tsp_ctrl_type'(`TSP_RST_CTRL);
			period_value_p <= `TSP_RST_PERIOD;
			compare_value_a <= `TSP_RST_CMPA;
			count_reg      <= `TSP_RST_COUNT;
			run_prev_reg   <= 1'b0;
			trig_prev_reg  <= 1'b0;
			cap_prev_reg   <= 1'b0;
			pulse_reg      <= 1'b0;
		end else begin
			ctrl_reg      <= ctrl_next;
			count_reg     <= count_next;
			run_prev_reg  <= run;
			trig_prev_reg <= external_trigger_pin;
			cap_prev_reg  <= cap_pin;
			pulse_reg     <= pulse_mode && ctrl_next.counter_run_bit;          // RL2 RL4
			if (bus_req.wr && bus_req.addr == `TSP_ADDR_PERIOD)
				period_value_p <= bus_req.wdata[2:0];
			if (do_capture)
				compare_value_a <= count_reg;                                  // RL11
			else if (bus_req.wr && bus_req.addr == `TSP_ADDR_CMPA)
				compare_value_a <= bus_req.wdata;
		end
	end

	// output pin: active level and invert apply only in pulse mode
	wire logic out_next = pulse_mode ?
	                      ((pulse_reg ~^ ctrl_reg.output_initial_level) ^ ctrl_reg.output_invert) : 1'b0; // RL17 RL8
	wire logic irq_next = match_a || match_p || do_capture;                    // RL6 RL15 RL11
	wire logic [9:0] rd_mux = (bus_req.addr == `TSP_ADDR_CTRL)   ? {1'b0, ctrl_reg} :
	                          (bus_req.addr == `TSP_ADDR_PERIOD) ? {7'h00, period_value_p} :
	                          (bus_req.addr == `TSP_ADDR_CMPA)   ? compare_value_a :
	                          (bus_req.addr == `TSP_ADDR_COUNT)  ? count_reg :
	                          (bus_req.addr == `TSP_ADDR_STATUS) ? {8'h00, pulse_reg, run} : 10'h000;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_out <= 1'b0;
			timer_irq <= 1'b0;
			bus_rdata <= 10'h000;
		end else begin
			timer_out <= out_next;
			timer_irq <= irq_next;
			bus_rdata <= bus_req.rd ? rd_mux : 10'h000;
		end
	end

	a_pulse_a_stop: assert property ( // RL5
		@(posedge core_clk) disable iff (!reset_n)
		match_a && !trig_set
		|=> !run
	) else
		$error("compare A match did not clear run");

	a_pulse_a_irq: assert property ( // RL6
		@(posedge core_clk) disable iff (!reset_n)
		match_a
		|=> timer_irq
	) else
		$error("compare A match gave no interrupt");

	a_run_rise_clear: assert property ( // RL7
		@(posedge core_clk) disable iff (!reset_n)
		run_rise
		|=> count_reg == `TSP_RST_COUNT
	) else
		$error("run rise did not clear counter");

	a_trig_sets_run: assert property ( // RL3
		@(posedge core_clk) disable iff (!reset_n)
		trig_set
		|=> run
	) else
		$error("trigger did not set run");

	a_capture_copy: assert property ( // RL11
		@(posedge core_clk) disable iff (!reset_n)
		do_capture
		|=> compare_value_a == $past(count_reg) && timer_irq
	) else
		$error("capture failed");

	a_period_wrap: assert property ( // RL14
		@(posedge core_clk) disable iff (!reset_n)
		match_p && !run_rise
		|=> count_reg == `TSP_RST_COUNT && timer_irq
	) else
		$error("period match missed");

	a_stop_hold: assert property ( // RL21
		@(posedge core_clk) disable iff (!reset_n)
		!run && !$past(run)
		|-> $stable(count_reg)
	) else
		$error("stopped counter moved");

	a_pulse_level: assert property ( // RL4
		@(posedge core_clk) disable iff (!reset_n)
		pulse_mode
		|=> pulse_reg == run
	) else
		$error("pulse state does not follow run");

	a_cap_off: assert property ( // RL12
		@(posedge core_clk) disable iff (!reset_n)
		pinf_w == `TSP_PIN_OFF
		|-> !do_capture
	) else
		$error("capture while disabled");

	a_pulse_lead_edge: assert property ( // RL2
		@(posedge core_clk) disable iff (!reset_n)
		pulse_mode && $past(pulse_mode) && run_rise
		|=> timer_out == $past(active_lvl)
	) else
		$error("pulse leading edge missing");

	a_pulse_trail_edge: assert property ( // RL4
		@(posedge core_clk) disable iff (!reset_n)
		pulse_mode && !pulse_reg
		|=> timer_out != $past(active_lvl)
	) else
		$error("output active with pulse ended");

	a_cap_no_out: assert property ( // RL17
		@(posedge core_clk) disable iff (!reset_n)
		!pulse_mode
		|=> !timer_out
	) else
		$error("output driven outside pulse mode");

	a_pulse_no_period: assert property ( // RL8
		@(posedge core_clk) disable iff (!reset_n)
		pulse_mode
		|-> !match_p
	) else
		$error("period match in pulse mode");

	a_pulse_hold_zero: assert property ( // RL7
		@(posedge core_clk) disable iff (!reset_n)
		pulse_mode && !run_rise && count_reg != `TSP_RST_COUNT && count_reg != `TSP_COUNT_MAX
		|=> count_reg != `TSP_RST_COUNT
	) else
		$error("pulse counter cleared without run rise");

	a_cap_count_step: assert property ( // RL13
		@(posedge core_clk) disable iff (!reset_n)
		cap_mode && counting && !match_p
		|=> count_reg == $past(count_reg) + 10'h001
	) else
		$error("capture counter did not advance");

	a_cap_start_clear: assert property ( // RL10
		@(posedge core_clk) disable iff (!reset_n)
		cap_mode && run_rise
		|=> count_reg == `TSP_RST_COUNT
	) else
		$error("capture counter did not start from zero");

	a_period_irq: assert property ( // RL15
		@(posedge core_clk) disable iff (!reset_n)
		match_p
		|=> timer_irq
	) else
		$error("period match gave no interrupt");

	a_full_period_max: assert property ( // RL16
		@(posedge core_clk) disable iff (!reset_n)
		match_p && period_value_p == `TSP_PERIOD_FULL
		|-> count_reg == `TSP_COUNT_MAX
	) else
		$error("zero period wrapped early");

	a_full_period_hit: assert property ( // RL16
		@(posedge core_clk) disable iff (!reset_n)
		cap_mode && counting && period_value_p == `TSP_PERIOD_FULL && count_reg == `TSP_COUNT_MAX
		|-> match_p
	) else
		$error("zero period missed full count");

	a_period_bits: assert property ( // RL20
		@(posedge core_clk) disable iff (!reset_n)
		cap_mode && counting && period_value_p != `TSP_PERIOD_FULL && count_reg[9:7] == period_value_p
		|-> match_p
	) else
		$error("period bits matched without match");

	a_irq_cause: assert property ( // RL6
		@(posedge core_clk) disable iff (!reset_n)
		!match_a && !match_p && !do_capture
		|=> !timer_irq
	) else
		$error("interrupt without event");

	a_run_edge_seen: assert property ( // RL22
		@(posedge core_clk) disable iff (!reset_n)
		$rose(run)
		|-> run_rise
	) else
		$error("run rise not detected");

	a_trig_edge_seen: assert property ( // RL22
		@(posedge core_clk) disable iff (!reset_n)
		pulse_mode && $rose(external_trigger_pin)
		|-> trig_set
	) else
		$error("trigger edge not detected");

	a_cap_second_pin: assert property ( // RL23
		@(posedge core_clk) disable iff (!reset_n)
		cap_mode && run && pinf_w == `TSP_PIN_RISE && capture_pin_select && $past(capture_pin_select)
		&& $rose(capture_pin_second)
		|-> do_capture
	) else
		$error("second capture pin not watched");

	a_cap_fall_only: assert property ( // RL12
		@(posedge core_clk) disable iff (!reset_n)
		pinf_w == `TSP_PIN_FALL && !cap_fall
		|-> !do_capture
	) else
		$error("capture on wrong edge");

	a_cap_both_edges: assert property ( // RL12
		@(posedge core_clk) disable iff (!reset_n)
		cap_mode && run && pinf_w == `TSP_PIN_BOTH && (cap_rise || cap_fall)
		|-> do_capture
	) else
		$error("capture missed on either edge");

	a_count_wrap: assert property ( // RL19
		@(posedge core_clk) disable iff (!reset_n)
		counting && !match_a && !match_p && count_reg == `TSP_COUNT_MAX
		|=> count_reg == `TSP_RST_COUNT
	) else
		$error("counter did not wrap at ten bits");

	a_cap_a_hold: assert property ( // RL11
		@(posedge core_clk) disable iff (!reset_n)
		!do_capture && !(bus_req.wr && bus_req.addr == `TSP_ADDR_CMPA)
		|=> $stable(compare_value_a)
	) else
		$error("compare A changed without cause");

	a_cap_off_runs: assert property ( // RL12
		@(posedge core_clk) disable iff (!reset_n)
		cap_mode && pinf_w == `TSP_PIN_OFF && counting && !match_p
		|=> count_reg != $past(count_reg)
	) else
		$error("counter stopped with capture disabled");

endmodule // tsp_timer

// File: tsp_map.svh
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH

// register word indices on the plain software port
`define TSP_ADDR_CTRL      4'h0
`define TSP_ADDR_PERIOD    4'h1
`define TSP_ADDR_CMPA      4'h2
`define TSP_ADDR_COUNT     4'h3
`define TSP_ADDR_STATUS    4'h4

// control word fields
`define TSP_CTRL_MODE_LSB  0
`define TSP_CTRL_PIN_LSB   2
`define TSP_CTRL_OIL_BIT   4
`define TSP_CTRL_INV_BIT   5
`define TSP_CTRL_CLR_BIT   6
`define TSP_CTRL_DPX_BIT   7
`define TSP_CTRL_RUN_BIT   8

// mode and pin function codes
`define TSP_MODE_CAPTURE   2'h1
`define TSP_MODE_PULSE     2'h2
`define TSP_PIN_PULSE      2'h3
`define TSP_PIN_RISE       2'h0
`define TSP_PIN_FALL       2'h1
`define TSP_PIN_BOTH       2'h2
`define TSP_PIN_OFF        2'h3

// reset values
`define TSP_RST_CTRL       9'h000
`define TSP_RST_PERIOD     3'h0
`define TSP_RST_CMPA       10'h000
`define TSP_RST_COUNT      10'h000

// counter limits
`define TSP_COUNT_MAX      10'h3ff
`define TSP_PERIOD_FULL    3'h0

`endif

// File: tsp_pkg.sv
package tsp_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [9:0] wdata;
		logic       wr;
		logic       rd;
	} tsp_bus_req_type;

	typedef struct packed {
		logic       counter_run_bit;
		logic       duty_period_swap;
		logic       clear_source_select;
		logic       output_invert;
		logic       output_initial_level;
		logic       pin_function_sel_hi;
		logic       pin_function_sel_lo;
		logic       timer_mode_sel_hi;
		logic       timer_mode_sel_lo;
	} tsp_ctrl_type;
endpackage

// File: tsp_pin_source.sv
`timescale 1ns/1ps
module tsp_pin_source (
	input  wire logic core_clk,         // system clock
	output logic      trig_pin = 1'b0,  // trigger line
	output logic      cap_a    = 1'b0,  // first capture line
	output logic      cap_b    = 1'b0   // second capture line
);
	// one rising edge, held long enough to be sampled
	task automatic fire;
		@(posedge core_clk);
		trig_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
		trig_pin <= 1'b0;
	endtask
	task automatic drive_cap(input logic sel, input logic lvl);
		@(posedge core_clk);
		if (sel) begin
			cap_b <= lvl;
		end else begin
			cap_a <= lvl;
		end
		repeat (4) @(posedge core_clk);
	endtask
endmodule // tsp_pin_source

// File: timer_single_pulse_capture_test.sv
`timescale 1ns/1ps
`include "tsp_map.svh"
module timer_single_pulse_capture_test import tsp_pkg::*; ;
	logic            core_clk = 1'b0;
	logic            reset_n = 1'b0;
	logic            pin_sel = 1'b0;
	logic            tick = 1'b1;
	logic            half = 1'b0;
	tsp_bus_req_type bus_req = '0;
	logic      [9:0] rdata, c1, c2;
	logic            trig, cap_a, cap_b, timer_out, timer_irq;
	int              miscompares = 0;
	int              checks = 0;
	int              irqs = 0;
	int              highs = 0;
	int              i0, h0;
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) tick <= half ? ~tick : 1'b1;
	always @(posedge core_clk) begin
		irqs <= irqs + (timer_irq === 1'b1);
		highs <= highs + (timer_out === 1'b1);
	end
	tsp_pin_source u_src (.core_clk(core_clk), .trig_pin(trig), .cap_a(cap_a), .cap_b(cap_b));
	tsp_timer u_dut (.core_clk(core_clk), .reset_n(reset_n), .count_tick(tick), .bus_req(bus_req),
		.bus_rdata(rdata), .external_trigger_pin(trig), .capture_pin_first(cap_a),
		.capture_pin_second(cap_b), .capture_pin_select(pin_sel), .timer_out(timer_out), .timer_irq(timer_irq));
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [9:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [9:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 10'h000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		@(negedge core_clk);
		d = rdata;
	endtask
	task automatic wait_irq(input int lim);
		for (int n = 0; n < lim && irqs == i0; n++) @(posedge core_clk);
		repeat (3) @(posedge core_clk);
	endtask
	task automatic conclude;
		if (miscompares == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic t_pulses;
		for (int a = 0; a < 8; a++) begin
			rd(a[3:0], c1);
			check(c1, 10'h000);
		end
		wr(`TSP_ADDR_PERIOD, 10'h001);
		wr(`TSP_ADDR_CMPA, 10'h0c8);
		i0 = irqs;
		h0 = highs;
		wr(`TSP_ADDR_CTRL, 10'h1de);
		wait_irq(400);
		check(10'(irqs - i0), 10'h001);
		check(10'(highs - h0 > 199 && highs - h0 < 204), 10'h001);
		rd(`TSP_ADDR_COUNT, c1);
		check(c1, 10'h0c8);
		rd(`TSP_ADDR_CTRL, c1);
		check(c1, 10'h0de);
		wr(`TSP_ADDR_CMPA, 10'h014);
		wr(`TSP_ADDR_CTRL, 10'h01e);
		i0 = irqs;
		h0 = highs;
		half <= 1'b1;
		u_src.fire();
		wait_irq(100);
		half <= 1'b0;
		check(10'(highs - h0 > 38 && highs - h0 < 48), 10'h001);
		rd(`TSP_ADDR_COUNT, c1);
		check(c1, 10'h014);
		check(10'(irqs - i0), 10'h001);
		wr(`TSP_ADDR_CMPA, 10'h1f4);
		i0 = irqs;
		wr(`TSP_ADDR_CTRL, 10'h11e);
		repeat (30) @(posedge core_clk);
		wr(`TSP_ADDR_CTRL, 10'h01e);
		repeat (3) @(posedge core_clk);
		check({9'h000, timer_out}, 10'h000);
		rd(`TSP_ADDR_COUNT, c1);
		repeat (10) @(posedge core_clk);
		rd(`TSP_ADDR_COUNT, c2);
		check(c2, c1);
		check(10'(irqs - i0), 10'h000);
	endtask
	task automatic t_capture;
		wr(`TSP_ADDR_PERIOD, 10'h000);
		for (int f = 0; f < 4; f++) begin
			pin_sel <= f[0];
			h0 = highs;
			wr(`TSP_ADDR_CTRL, 10'h131 | 10'(f << 2));
			i0 = irqs;
			u_src.drive_cap(~pin_sel, 1'b1);
			u_src.drive_cap(~pin_sel, 1'b0);
			u_src.drive_cap(pin_sel, 1'b1);
			u_src.drive_cap(pin_sel, 1'b0);
			check(10'(irqs - i0), (f == 3) ? 10'h000 : (f == 2) ? 10'h002 : 10'h001);
			check(10'(highs - h0), 10'h000);
			rd(`TSP_ADDR_CMPA, c1);
			rd(`TSP_ADDR_COUNT, c2);
			check({9'h000, c1 < c2 && c1 != 10'h000}, 10'h001);
			check(c1, (f == 0) ? 10'h00a : 10'h00f);
			wr(`TSP_ADDR_CTRL, 10'h000);
		end
		wr(`TSP_ADDR_PERIOD, 10'h001);
		wr(`TSP_ADDR_CTRL, 10'h101);
		i0 = irqs;
		repeat (118) @(posedge core_clk);
		check(10'(irqs - i0), 10'h000);
		wait_irq(30);
		check(10'(irqs - i0), 10'h001);
		rd(`TSP_ADDR_COUNT, c1);
		check({9'h000, c1 < 10'h00a}, 10'h001);
		wr(`TSP_ADDR_PERIOD, 10'h000);
		wr(`TSP_ADDR_CTRL, 10'h001);
		wr(`TSP_ADDR_CTRL, 10'h101);
		i0 = irqs;
		repeat (1000) @(posedge core_clk);
		check(10'(irqs - i0), 10'h000);
		wait_irq(60);
		check(10'(irqs - i0), 10'h001);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		conclude();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		t_pulses();
		t_capture();
		conclude();
	end
endmodule // timer_single_pulse_capture_test
